// file: rtl/ped_event_detect.sv
// Event qualification and the two performance counters.
// Assumes core-side strobes on CORE_CLK; bus ownership pins are
// asynchronous and pass a two-stage synchroniser.
`timescale 1ns/1ns

// Behaviour
// - Code 22H counts basic float operations
// - Transcendental internal add and multiply each count
// - Zero-divide, neg-sqrt, special, stack faults excluded
// - Other faults, integer multiply, float-unit uses count
// - Codes 23H-26H count breakpoint zero-three matches
// - Matches count even with breakpoints disabled
// - Disabled code breakpoints match primary pipe only
// - Match events equal the breakpoint match pins
// - Code 27H counts taken maskable and NMI
// - Code 28H counts data reads and writes
// - Split halves separate; page walks, I/O excluded
// - Data access event adds up to two
// - Code 29H counts data cache misses
// - No extra misses during burst fill window
// - Miss event excludes page walks and I/O
// - Counter 0 2AH counts ownership wait clocks
// - Counter 1 2AH counts private request assertions
module ped_event_detect
   import ped_pkg::*;
(
   // Clock and reset
   input  wire  logic                        CORE_CLK,
   input  wire  logic                        RST_N,
   // Event selection
   input  wire  logic [ped_pkg::SEL_W-1:0]   EVENT_SEL_0,
   input  wire  logic [ped_pkg::SEL_W-1:0]   EVENT_SEL_1,
   // Floating-point unit
   input  wire  logic                        FP_OP_DONE,
   input  wire  logic                        FP_TRANSC_ADD,
   input  wire  logic                        FP_TRANSC_MUL,
   input  wire  logic                        FP_EXC_ZERO_DIVIDE,
   input  wire  logic                        FP_EXC_NEG_SQRT,
   input  wire  logic                        FP_EXC_SPECIAL_OPND,
   input  wire  logic                        FP_EXC_STACK,
   // Debug breakpoint compare
   input  wire  logic [ped_pkg::NUM_BKPT-1:0] BP_DATA_MATCH,
   input  wire  logic [ped_pkg::NUM_BKPT-1:0] BP_CODE_MATCH_U,
   input  wire  logic [ped_pkg::NUM_BKPT-1:0] BP_CODE_MATCH_V,
   input  wire  logic [ped_pkg::NUM_BKPT-1:0] BP_ENABLED,
   // Interrupt unit
   input  wire  logic                        MASKABLE_IRQ_TAKEN,
   input  wire  logic                        NMI_TAKEN,
   // Data cache, one lane per pipe
   input  wire  logic [ped_pkg::NUM_DPORT-1:0] DC_ACCESS,
   input  wire  logic [ped_pkg::NUM_DPORT-1:0] DC_MISS,
   input  wire  logic [ped_pkg::NUM_DPORT-1:0] DC_IO_SPACE,
   input  wire  logic [ped_pkg::NUM_DPORT-1:0] DC_PAGE_WALK,
   input  wire  logic [ped_pkg::LINE_W-1:0]  DC_LINE_0,
   input  wire  logic [ped_pkg::LINE_W-1:0]  DC_LINE_1,
   // Bus unit line fill
   input  wire  logic                        FILL_START,
   input  wire  logic [ped_pkg::LINE_W-1:0]  FILL_LINE,
   input  wire  logic                        BURST_READY_STROBE,
   // Dual-processor ownership pins
   input  wire  logic                        PRIVATE_BUS_REQUEST,
   input  wire  logic                        PRIVATE_BUS_GRANT,
   input  wire  logic                        PEER_HIT_MODIFIED_N,
   input  wire  logic                        SNOOP_HIT_MODIFIED_N,
   // Results
   output logic [ped_pkg::NUM_BKPT-1:0]      BREAKPOINT_MATCH_PINS,
   output logic [1:0]                        COUNT_INC_0,
   output logic [1:0]                        COUNT_INC_1,
   output logic [ped_pkg::CTR_W-1:0]         COUNTER_0,
   output logic [ped_pkg::CTR_W-1:0]         COUNTER_1
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   ped_state_t          st_r;
   ped_state_t          st_nxt;
   logic [1:0]          fp_cnt;
   logic                fp_excluded;
   logic [NUM_BKPT-1:0] bp_hit;
   logic [1:0]          irq_cnt;
   logic [1:0]          rw_cnt;
   logic [1:0]          miss_cnt;
   logic [NUM_DPORT-1:0] rw_ok;
   logic [NUM_DPORT-1:0] miss_ok;
   logic [NUM_DPORT-1:0] miss_hide;
   logic [LINE_W-1:0]   dc_line [NUM_DPORT];
   logic                private_bus_request_s;
   logic                grant_s;
   logic                any_req;
   logic                lat_evt;
   logic                xfer_evt;
   logic [SEL_W-1:0]    sel [2];
   logic [1:0]          incr [2];
   logic                grant_meta_r;
   logic                grant_lvl_r;

   // ----------------------------------------------------------------
   // Floating-point operation event
   // ----------------------------------------------------------------
   assign fp_excluded = FP_EXC_ZERO_DIVIDE  |
                        FP_EXC_NEG_SQRT     |
                        FP_EXC_SPECIAL_OPND |
                        FP_EXC_STACK;

   // Done covers plain ops, integer multiply and other unit uses
   assign fp_cnt = fp_excluded ? INC_ZERO :
                   2'({1'b0, FP_OP_DONE} +
                      {1'b0, FP_TRANSC_ADD} +
                      {1'b0, FP_TRANSC_MUL});

   // ----------------------------------------------------------------
   // Breakpoint match events
   // ----------------------------------------------------------------
   // Secondary pipe code matches only when the breakpoint is armed
   assign bp_hit = BP_DATA_MATCH |
                   BP_CODE_MATCH_U |
                   (BP_CODE_MATCH_V & BP_ENABLED);

   // ----------------------------------------------------------------
   // Interrupt event
   // ----------------------------------------------------------------
   assign irq_cnt = 2'({1'b0, MASKABLE_IRQ_TAKEN} +
                       {1'b0, NMI_TAKEN});

   // ----------------------------------------------------------------
   // Data access and miss events, per lane
   // ----------------------------------------------------------------
   assign dc_line[0] = DC_LINE_0;
   assign dc_line[1] = DC_LINE_1;

   genvar gl;
   generate
      for (gl = 0; gl < NUM_DPORT; gl++) begin : g_lane
         // Each split half arrives as its own strobe
         assign rw_ok[gl] = DC_ACCESS[gl] &
                            ~DC_IO_SPACE[gl] &
                            ~DC_PAGE_WALK[gl];
         // Inside the burst window a same-line read is not a new miss
         assign miss_hide[gl] = (st_r.fill_state == FILL_BUSY) &&
                                (st_r.burst_ready_strobe_cnt != BURST_READY_STROBE_ZERO) &&
                                (dc_line[gl] == st_r.fill_line);
         assign miss_ok[gl] = DC_ACCESS[gl] &
                              DC_MISS[gl] &
                              ~DC_IO_SPACE[gl] &
                              ~DC_PAGE_WALK[gl] &
                              ~miss_hide[gl];
      end
   endgenerate

   assign rw_cnt   = 2'({1'b0, rw_ok[0]} + {1'b0, rw_ok[1]});
   assign miss_cnt = 2'({1'b0, miss_ok[0]} + {1'b0, miss_ok[1]});

   // ----------------------------------------------------------------
   // Bus ownership events
   // ----------------------------------------------------------------
   assign private_bus_request_s = st_r.sync_lvl[SYN_PRIVATE_BUS_REQUEST];
   assign grant_s = grant_lvl_r;
   assign any_req = private_bus_request_s |
                    ~st_r.sync_lvl[SYN_PEER_HIT_MODIFIED] |
                    ~st_r.sync_lvl[SYN_SNOOP_HIT_MODIFIED];

   // Wait clocks run from the earliest request until the grant
   assign lat_evt  = (st_r.own_pending | any_req) & ~grant_s;
   assign xfer_evt = private_bus_request_s & ~st_r.private_bus_request_prev;

   // ----------------------------------------------------------------
   // Per-counter event decode
   // ----------------------------------------------------------------
   function automatic logic [1:0] ev_count(input logic [SEL_W-1:0] code,
                                           input logic             second);
      logic [1:0] n;
      n = INC_ZERO;
      case (code)
         EVT_FLOAT_OPS:  n = fp_cnt;
         EVT_BKPT_ZERO:  n = {1'b0, bp_hit[0]};
         EVT_BKPT_ONE:   n = {1'b0, bp_hit[1]};
         EVT_BKPT_TWO:   n = {1'b0, bp_hit[2]};
         EVT_BKPT_THREE: n = {1'b0, bp_hit[3]};
         EVT_HW_IRQ:     n = irq_cnt;
         EVT_DATA_RW:    n = rw_cnt;
         EVT_DATA_MISS:  n = miss_cnt;
         EVT_BUS_OWN:    n = second ? {1'b0, xfer_evt}
                                    : {1'b0, lat_evt};
         default:        n = INC_ZERO;
      endcase
      return n;
   endfunction

   assign sel[0] = EVENT_SEL_0;
   assign sel[1] = EVENT_SEL_1;

   genvar gc;
   generate
      for (gc = 0; gc < 2; gc++) begin : g_ctr
         // Process form so the decode follows every event it reads
         always_comb begin
            incr[gc] = ev_count(sel[gc], 1'(gc));
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;

      // Pin synchroniser, first stage feeds only the second
      st_nxt.sync_meta = {SNOOP_HIT_MODIFIED_N,
                          PEER_HIT_MODIFIED_N,
                          PRIVATE_BUS_REQUEST};
      st_nxt.sync_lvl  = st_r.sync_meta;

      st_nxt.private_bus_request_prev  = private_bus_request_s;
      st_nxt.own_pending = (st_r.own_pending | any_req) & ~grant_s;

      // Line fill tracking, closed by the fourth burst ready
      unique case (st_r.fill_state)
         FILL_IDLE: begin
            if (FILL_START) begin
               st_nxt.fill_state = FILL_BUSY;
               st_nxt.fill_line  = FILL_LINE;
               st_nxt.burst_ready_strobe_cnt   = BURST_READY_STROBE_ZERO;
            end
         end
         FILL_BUSY: begin
            if (BURST_READY_STROBE) begin
               if (st_r.burst_ready_strobe_cnt == BURST_READY_STROBE_LAST) begin
                  st_nxt.fill_state = FILL_IDLE;
                  st_nxt.burst_ready_strobe_cnt   = BURST_READY_STROBE_ZERO;
               end else begin
                  st_nxt.burst_ready_strobe_cnt = 3'(st_r.burst_ready_strobe_cnt + BURST_READY_STROBE_ONE);
               end
            end
         end
      endcase

      st_nxt.bp_pins = bp_hit;
      st_nxt.inc0    = incr[0];
      st_nxt.inc1    = incr[1];
      st_nxt.ctr0    = CTR_W'(st_r.ctr0 + {{(CTR_W-2){1'b0}}, incr[0]});
      st_nxt.ctr1    = CTR_W'(st_r.ctr1 + {{(CTR_W-2){1'b0}}, incr[1]});
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_r.sync_meta   <= 3'h6;
         st_r.sync_lvl    <= 3'h6;
         st_r.private_bus_request_prev  <= 1'b0;
         st_r.own_pending <= 1'b0;
         st_r.fill_state  <= FILL_IDLE;
         st_r.fill_line   <= 27'h000_0000;
         st_r.burst_ready_strobe_cnt    <= BURST_READY_STROBE_ZERO;
         st_r.bp_pins     <= 4'h0;
         st_r.inc0        <= INC_ZERO;
         st_r.inc1        <= INC_ZERO;
         st_r.ctr0        <= CTR_RESET;
         st_r.ctr1        <= CTR_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Grant synchroniser, same two-stage form as the other pins
   // ----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         grant_meta_r <= 1'b0;
         grant_lvl_r  <= 1'b0;
      end else begin
         grant_meta_r <= PRIVATE_BUS_GRANT;
         grant_lvl_r  <= grant_meta_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign BREAKPOINT_MATCH_PINS = st_r.bp_pins;
   assign COUNT_INC_0           = st_r.inc0;
   assign COUNT_INC_1           = st_r.inc1;
   assign COUNTER_0             = st_r.ctr0;
   assign COUNTER_1             = st_r.ctr1;

endmodule

// file: rtl/ped_pkg.sv
// Constants and types for the performance event detector.
// Assumes one core clock and an active-low asynchronous reset.
package ped_pkg;

   // ----------------------------------------------------------------
   // Event select codes
   // ----------------------------------------------------------------
   localparam int          SEL_W          = 6;
   localparam logic [5:0]  EVT_FLOAT_OPS  = 6'h22;
   localparam logic [5:0]  EVT_BKPT_ZERO  = 6'h23;
   localparam logic [5:0]  EVT_BKPT_ONE   = 6'h24;
   localparam logic [5:0]  EVT_BKPT_TWO   = 6'h25;
   localparam logic [5:0]  EVT_BKPT_THREE = 6'h26;
   localparam logic [5:0]  EVT_HW_IRQ     = 6'h27;
   localparam logic [5:0]  EVT_DATA_RW    = 6'h28;
   localparam logic [5:0]  EVT_DATA_MISS  = 6'h29;
   localparam logic [5:0]  EVT_BUS_OWN    = 6'h2a;

   // ----------------------------------------------------------------
   // Widths and counts
   // ----------------------------------------------------------------
   localparam int          CTR_W          = 40;
   localparam int          LINE_W         = 27;
   localparam int          NUM_BKPT       = 4;
   localparam int          NUM_DPORT      = 2;
   localparam int          NUM_SYNC       = 3;
   localparam logic [2:0]  BURST_READY_STROBE_LAST      = 3'h3;
   localparam logic [2:0]  BURST_READY_STROBE_ZERO      = 3'h0;
   localparam logic [2:0]  BURST_READY_STROBE_ONE       = 3'h1;
   localparam logic [1:0]  INC_ZERO       = 2'h0;
   localparam logic [CTR_W-1:0] CTR_RESET = 40'h00_0000_0000;

   // ----------------------------------------------------------------
   // Pin synchroniser bit positions
   // ----------------------------------------------------------------
   localparam int          SYN_PRIVATE_BUS_REQUEST      = 0;
   localparam int          SYN_PEER_HIT_MODIFIED      = 1;
   localparam int          SYN_SNOOP_HIT_MODIFIED       = 2;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [0:0] {
      FILL_IDLE = 1'b0,
      FILL_BUSY = 1'b1
   } ped_fill_t;

   typedef struct packed {
      logic [NUM_SYNC-1:0] sync_meta;
      logic [NUM_SYNC-1:0] sync_lvl;
      logic                private_bus_request_prev;
      logic                own_pending;
      ped_fill_t           fill_state;
      logic [LINE_W-1:0]   fill_line;
      logic [2:0]          burst_ready_strobe_cnt;
      logic [NUM_BKPT-1:0] bp_pins;
      logic [1:0]          inc0;
      logic [1:0]          inc1;
      logic [CTR_W-1:0]    ctr0;
      logic [CTR_W-1:0]    ctr1;
   } ped_state_t;

endpackage

// file: testbench/ped_event_detect_properties.sv
// Concurrent checks on the event detector's ports.
// Assumes ped_pkg is compiled first; bound into ped_event_detect below.
`timescale 1ns/1ns
module ped_event_detect_properties
   import ped_pkg::*;
(
   input wire logic                          CORE_CLK, RST_N,
   input wire logic [ped_pkg::SEL_W-1:0]     EVENT_SEL_0, EVENT_SEL_1,
   input wire logic                          FP_OP_DONE, FP_TRANSC_ADD, FP_TRANSC_MUL,
   input wire logic                          FP_EXC_ZERO_DIVIDE, FP_EXC_NEG_SQRT,
   input wire logic                          FP_EXC_SPECIAL_OPND, FP_EXC_STACK,
   input wire logic [ped_pkg::NUM_BKPT-1:0]  BP_DATA_MATCH, BP_CODE_MATCH_U,
   input wire logic [ped_pkg::NUM_BKPT-1:0]  BP_CODE_MATCH_V, BP_ENABLED,
   input wire logic [ped_pkg::NUM_BKPT-1:0]  BREAKPOINT_MATCH_PINS,
   input wire logic                          MASKABLE_IRQ_TAKEN, NMI_TAKEN,
   input wire logic [ped_pkg::NUM_DPORT-1:0] DC_ACCESS, DC_IO_SPACE, DC_PAGE_WALK,
   input wire logic [1:0]                    COUNT_INC_0, COUNT_INC_1,
   input wire logic [ped_pkg::CTR_W-1:0]     COUNTER_0, COUNTER_1
);
   wire logic                 fp_exc = FP_EXC_ZERO_DIVIDE | FP_EXC_NEG_SQRT |
                                       FP_EXC_SPECIAL_OPND | FP_EXC_STACK;
   wire logic [NUM_DPORT-1:0] rw_ok  = DC_ACCESS & ~DC_IO_SPACE & ~DC_PAGE_WALK;

   default clocking dcb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);

   chk_ctr0_adds_inc: assert property (COUNTER_0 == $past(COUNTER_0) +
      CTR_W'(COUNT_INC_0)) else $error("counter 0 not previous plus increment");
   chk_ctr1_adds_inc: assert property (COUNTER_1 == $past(COUNTER_1) +
      CTR_W'(COUNT_INC_1)) else $error("counter 1 not previous plus increment");
   chk_float_sum: assert property (EVENT_SEL_0 == EVT_FLOAT_OPS && !fp_exc |=>
      COUNT_INC_0 == 2'($past(FP_OP_DONE)) + 2'($past(FP_TRANSC_ADD)) +
      2'($past(FP_TRANSC_MUL))) else $error("float increment wrong");
   chk_float_fault: assert property (EVENT_SEL_0 == EVT_FLOAT_OPS && fp_exc |=>
      COUNT_INC_0 == INC_ZERO) else $error("faulting float op counted");
   chk_bkpt_pins: assert property (1'b1 |=> BREAKPOINT_MATCH_PINS ==
      ($past(BP_DATA_MATCH) | $past(BP_CODE_MATCH_U) |
      ($past(BP_CODE_MATCH_V) & $past(BP_ENABLED)))) else $error("match pins wrong");
   chk_bkpt_count: assert property (EVENT_SEL_1 == EVT_BKPT_ZERO |=>
      COUNT_INC_1 == {1'b0, BREAKPOINT_MATCH_PINS[0]}) else $error("match count wrong");
   chk_irq_sum: assert property (EVENT_SEL_0 == EVT_HW_IRQ |=>
      COUNT_INC_0 == 2'($past(MASKABLE_IRQ_TAKEN)) + 2'($past(NMI_TAKEN)))
      else $error("interrupt increment wrong");
   chk_data_rw: assert property (EVENT_SEL_1 == EVT_DATA_RW |=>
      COUNT_INC_1 == 2'($past(rw_ok[0])) + 2'($past(rw_ok[1])))
      else $error("data access increment wrong");
   chk_bad_code: assert property (
      !(EVENT_SEL_0 inside {[EVT_FLOAT_OPS:EVT_BUS_OWN]}) |=> COUNT_INC_0 == INC_ZERO)
      else $error("unsupported code counted");
endmodule

bind ped_event_detect ped_event_detect_properties ped_event_detect_properties_inst (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .EVENT_SEL_0(EVENT_SEL_0),
   .EVENT_SEL_1(EVENT_SEL_1), .FP_OP_DONE(FP_OP_DONE), .FP_TRANSC_ADD(FP_TRANSC_ADD),
   .FP_TRANSC_MUL(FP_TRANSC_MUL), .FP_EXC_ZERO_DIVIDE(FP_EXC_ZERO_DIVIDE),
   .FP_EXC_NEG_SQRT(FP_EXC_NEG_SQRT), .FP_EXC_SPECIAL_OPND(FP_EXC_SPECIAL_OPND),
   .FP_EXC_STACK(FP_EXC_STACK), .BP_DATA_MATCH(BP_DATA_MATCH),
   .BP_CODE_MATCH_U(BP_CODE_MATCH_U), .BP_CODE_MATCH_V(BP_CODE_MATCH_V),
   .BP_ENABLED(BP_ENABLED), .BREAKPOINT_MATCH_PINS(BREAKPOINT_MATCH_PINS),
   .MASKABLE_IRQ_TAKEN(MASKABLE_IRQ_TAKEN), .NMI_TAKEN(NMI_TAKEN),
   .DC_ACCESS(DC_ACCESS), .DC_IO_SPACE(DC_IO_SPACE), .DC_PAGE_WALK(DC_PAGE_WALK),
   .COUNT_INC_0(COUNT_INC_0), .COUNT_INC_1(COUNT_INC_1),
   .COUNTER_0(COUNTER_0), .COUNTER_1(COUNTER_1));

// file: testbench/testbench.sv
// Self-checking bench for the event detector against a reference model.
// Assumes ped_pkg, the design and the bound checker are compiled first.
`timescale 1ns/1ns
module testbench;
   import ped_pkg::*;
   logic        clk, rst_n, fp_done, fp_add, fp_mul, irq, nmi;
   logic        fl_start, burst_ready_strobe, req, gnt, phit_n, hit_n, fb, pend, prev, rq, rany;
   logic [3:0]  fp_exc, bp_d, bp_u, bp_v, bp_en, pins, ep, s1, s2;
   logic [1:0]  acc, miss, io, walk, inc0, inc1;
   logic [26:0] ln0, ln1, fl_line, fln;
   logic [5:0]  sel0, sel1;
   logic [39:0] c0, c1, ec0, ec1;
   int          e[9], d0, d1, fcnt, cyc, mismatches, n_checks;
   logic [5:0]  codes[12] = '{6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28,
                              6'h29, 6'h2a, 6'h20, 6'h2b, 6'h3f};

   ped_event_detect ped_event_detect_inst (
      .CORE_CLK(clk), .RST_N(rst_n), .EVENT_SEL_0(sel0), .EVENT_SEL_1(sel1),
      .FP_OP_DONE(fp_done), .FP_TRANSC_ADD(fp_add), .FP_TRANSC_MUL(fp_mul),
      .FP_EXC_ZERO_DIVIDE(fp_exc[0]), .FP_EXC_NEG_SQRT(fp_exc[1]),
      .FP_EXC_SPECIAL_OPND(fp_exc[2]), .FP_EXC_STACK(fp_exc[3]),
      .BP_DATA_MATCH(bp_d), .BP_CODE_MATCH_U(bp_u), .BP_CODE_MATCH_V(bp_v),
      .BP_ENABLED(bp_en), .MASKABLE_IRQ_TAKEN(irq), .NMI_TAKEN(nmi),
      .DC_ACCESS(acc), .DC_MISS(miss), .DC_IO_SPACE(io), .DC_PAGE_WALK(walk),
      .DC_LINE_0(ln0), .DC_LINE_1(ln1), .FILL_START(fl_start), .FILL_LINE(fl_line),
      .BURST_READY_STROBE(burst_ready_strobe), .PRIVATE_BUS_REQUEST(req), .PRIVATE_BUS_GRANT(gnt),
      .PEER_HIT_MODIFIED_N(phit_n), .SNOOP_HIT_MODIFIED_N(hit_n),
      .BREAKPOINT_MATCH_PINS(pins), .COUNT_INC_0(inc0), .COUNT_INC_1(inc1),
      .COUNTER_0(c0), .COUNTER_1(c1));

   task automatic check(string nm, logic [39:0] seen, logic [39:0] exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         mismatches++;
         end_sim();
      end
   end

   // ----------------------------------------
   // Reference model, one step per edge
   // ----------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         {ec0, ec1, ep, fb, pend, prev} = '0;
         d0 = 0;
         d1 = 0;
         fcnt = 0;
         {s1, s2} = 8'h66;
      end else begin
         ep = bp_d | bp_u | (bp_v & bp_en);
         e[0] = (|fp_exc) ? 0 : fp_done + fp_add + fp_mul;
         for (int i = 0; i < 4; i++) e[1 + i] = ep[i];
         e[5] = irq + nmi;
         e[6] = 0;
         e[7] = 0;
         for (int l = 0; l < 2; l++) begin
            if (acc[l] && !io[l] && !walk[l]) begin
               e[6]++;
               if (miss[l] && !(fb && fcnt > 0 && (l ? ln1 : ln0) == fln)) e[7]++;
            end
         end
         rq = s2[0];
         rany = s2[0] | ~s2[1] | ~s2[2];
         e[8] = (pend | rany) & ~s2[3];
         pend = (pend | rany) & ~s2[3];
         d0 = (sel0 inside {[6'h22:6'h2a]}) ? e[sel0 - 6'h22] : 0;
         d1 = (sel1 == 6'h2a) ? int'(rq & ~prev) :
              (sel1 inside {[6'h22:6'h29]}) ? e[sel1 - 6'h22] : 0;
         prev = rq;
         s2 = s1;
         s1 = {gnt, hit_n, phit_n, req};
         if (fb && burst_ready_strobe) begin
            fcnt++;
            fb = (fcnt < 4);
         end else if (!fb && fl_start) begin
            fb = 1'b1;
            fcnt = 0;
            fln = fl_line;
         end
         ec0 += 40'(d0);
         ec1 += 40'(d1);
      end
      #2;
      check("COUNTER_0", c0, ec0);
      check("COUNTER_1", c1, ec1);
      check("COUNT_INC_0", 40'(inc0), 40'(d0));
      check("COUNT_INC_1", 40'(inc1), 40'(d1));
      check("BREAKPOINT_MATCH_PINS", 40'(pins), 40'(ep));
   end

   task automatic idle();
      {fp_done, fp_add, fp_mul, irq, nmi, fl_start, burst_ready_strobe} = '0;
      {fp_exc, bp_d, bp_u, bp_v, bp_en, acc, miss, io, walk} = '0;
      {ln0, ln1, fl_line} = '0;
   endtask

   task automatic rnd();
      {fp_done, fp_add, fp_mul, irq, nmi} = 5'($urandom);
      fp_exc = ($urandom % 3 == 0) ? 4'h1 << ($urandom % 4) : 4'h0;
      {bp_d, bp_u, bp_v, bp_en} = 16'($urandom);
      {acc, miss} = 4'($urandom);
      io = 2'($urandom) & 2'($urandom);
      walk = 2'($urandom) & 2'($urandom);
      {ln0, ln1, fl_line} = {27'($urandom % 2), 27'($urandom % 2), 27'($urandom % 2)};
      fl_start = ($urandom % 6 == 0);
      burst_ready_strobe = fb && ($urandom % 2 == 1);
      if ($urandom % 6 == 0) {gnt, hit_n, phit_n, req} = 4'($urandom);
   endtask

   initial begin
      rst_n = 1'b0;
      {sel0, sel1, req, gnt, hit_n, phit_n} = {13'h0, 3'b111};
      idle();
      void'($urandom(32'hd48ba2e3));
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      // Every code on both counters, paired differently
      foreach (codes[i]) begin
         @(negedge clk);
         sel0 = codes[i];
         sel1 = codes[(i + 5) % 12];
         repeat (40) begin
            @(negedge clk);
            rnd();
         end
      end
      // Ownership wait clocks and transfers
      @(negedge clk);
      idle();
      {sel0, sel1, gnt, hit_n, phit_n, req} = {6'h2a, 6'h2a, 4'b0111};
      repeat (6) @(negedge clk);
      gnt = 1'b1;
      repeat (4) @(negedge clk);
      {gnt, req, hit_n} = 3'b000;
      repeat (5) @(negedge clk);
      {gnt, hit_n} = 2'b11;
      repeat (4) @(negedge clk);
      // Drain any fill left busy by the random phase
      burst_ready_strobe = 1'b1;
      repeat (4) @(negedge clk);
      burst_ready_strobe = 1'b0;
      // Same-line misses across a whole burst fill
      {sel0, sel1, fl_line, fl_start} = {6'h29, 6'h28, 27'h5, 1'b1};
      {ln0, ln1, acc, miss} = {27'h5, 27'h5, 4'b1111};
      @(negedge clk);
      fl_start = 1'b0;
      repeat (4) begin
         burst_ready_strobe = 1'b1;
         @(negedge clk);
         burst_ready_strobe = 1'b0;
         @(negedge clk);
      end
      // Reset in mid-run
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      end_sim();
   end
endmodule
